/* hw/sadc_sequencer_control.sv */
`timescale 1ns/1ps
module sadc_sequencer_control (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic                 ce,
   input  wire logic [11:0]          awaddr,
   input  wire logic                 awvalid,
   output      logic                 awready,
   input  wire logic [31:0]          wdata,
   input  wire logic [3:0]           wstrb,
   input  wire logic                 wvalid,
   output      logic                 wready,
   output      logic [1:0]           bresp,
   output      logic                 bvalid,
   input  wire logic                 bready,
   input  wire logic [11:0]          araddr,
   input  wire logic                 arvalid,
   output      logic                 arready,
   output      logic [31:0]          rdata,
   output      logic [1:0]           rresp,
   output      logic                 rvalid,
   input  wire logic                 rready,
   input  wire logic                 hw_trigger,
   input  wire logic [11:0]          core_result,
   output      sadc_pkg::sadc_core_s core,
   output      logic                 irq
);
   import sadc_pkg::*;

   function automatic logic [3:0] div_last(input logic [1:0] sel);
      case (sel)
         2'b00:   div_last = 4'd1;
         2'b01:   div_last = 4'd3;
         2'b10:   div_last = 4'd7;
         default: div_last = 4'd15;
      endcase
   endfunction

   // Lowest enabled channel above 'from', or any enabled one when 'any' is set; bit 2 flags a hit.
   function automatic logic [2:0] next_chan(input logic [3:0] mask, input logic [1:0] from, input logic any);
      next_chan = 3'b000;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (mask[i] && (any || i > int'(from))) begin
            next_chan = {1'b1, 2'(i)};
         end
      end
   endfunction

   function automatic logic [15:0] fmt16(input logic [RES_W-1:0] r, input logic left);
      fmt16 = left ? {r, 4'h0} : {4'h0, r};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Bus slave.
   logic              aw_held, w_held, next_aw_held, next_w_held;
   logic [11:0]       aw_addr, next_aw_addr;
   logic [7:0]        w_byte, next_w_byte;
   logic              w_lane, next_w_lane;
   logic              next_bvalid, next_rvalid;
   logic [1:0]        next_bresp, next_rresp;
   logic [31:0]       next_rdata;
   logic              do_write, wr_hit;

   logic [7:0]        cfg, next_cfg, ctl2, next_ctl2;
   logic [3:0]        chen, next_chen;
   logic [IRQ_W-1:0]  irq_st, next_irq_st, irq_en, next_irq_en, irq_set, irq_clr;
   logic [RES_W-1:0]  result [NUM_CH];
   logic [RES_W-1:0]  next_result [NUM_CH];
   sadc_state_e       state, next_state;
   logic              hw_run, next_hw_run;
   logic [3:0]        pre_cnt, next_pre_cnt;
   logic [5:0]        tick_cnt, next_tick_cnt;
   logic [1:0]        cur_ch, next_cur_ch;
   sadc_core_s        next_core;
   logic              powered, tick;
   logic [2:0]        pick;
   logic [1:0]        th_en;
   logic [15:0]       rd_fmt;

   assign awready  = !aw_held && !bvalid;
   assign wready   = !w_held && !bvalid;
   assign arready  = !rvalid;
   assign do_write = aw_held && w_held && !bvalid;
   assign powered  = cfg[CFG_POWER_BIT];
   assign th_en    = ctl2[CTL2_TH_LO_BIT +: 2];
   assign tick     = powered && (pre_cnt == div_last(cfg[CFG_DIV_HI_BIT:CFG_DIV_LO_BIT]));
   assign rd_fmt   = fmt16(result[araddr[4:3]], cfg[CFG_JUST_BIT]);

   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_byte  = w_byte;
      next_w_lane  = w_lane;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rresp   = rresp;
      next_rdata   = rdata;
      wr_hit       = 1'b0;
      if (awvalid && awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         next_w_held = 1'b1;
         next_w_byte = wdata[7:0];
         next_w_lane = wstrb[0];
      end
      if (do_write) begin
         wr_hit       = aw_addr == CFG_ADDR || aw_addr == CTL2_ADDR || aw_addr == CHEN_ADDR
                        || aw_addr == IRQ_CLR_ADDR || aw_addr == IRQ_EN_ADDR;
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
         next_bvalid = 1'b0;
      end
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         next_rdata  = 32'h0000_0000;
         if (araddr[11:5] == RESULT_BASE[11:5] && araddr[1:0] == 2'b00) begin
            next_rdata[7:0] = araddr[2] ? rd_fmt[7:0] : rd_fmt[15:8];
         end else begin
            case (araddr)
               CFG_ADDR:      next_rdata[7:0] = cfg;
               CTL2_ADDR:     next_rdata[7:0] = ctl2;
               CHEN_ADDR:     next_rdata[3:0] = chen;
               STATE_ADDR:    next_rdata[6:0] = {hw_run, cur_ch, state};
               IRQ_STAT_ADDR: next_rdata[IRQ_W-1:0] = irq_st;
               IRQ_CLR_ADDR:  next_rdata = 32'h0000_0000;
               IRQ_EN_ADDR:   next_rdata[IRQ_W-1:0] = irq_en;
               default:       next_rresp = RESP_SLVERR;
            endcase
         end
      end else if (rvalid && rready) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 12'h000;
         w_held  <= 1'b0;
         w_byte  <= 8'h00;
         w_lane  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
         rvalid  <= 1'b0;
         rresp   <= RESP_OKAY;
         rdata   <= 32'h0000_0000;
      end else if (ce) begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held  <= next_w_held;
         w_byte  <= next_w_byte;
         w_lane  <= next_w_lane;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         rvalid  <= next_rvalid;
         rresp   <= next_rresp;
         rdata   <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Configuration, sequencer, prescaler and interrupt.
   logic wr_lane0, cfg_wr, soft_wr;

   assign wr_lane0 = do_write && w_lane;
   assign cfg_wr   = wr_lane0 && aw_addr == CFG_ADDR;
   assign soft_wr  = cfg_wr && w_byte[CFG_START_BIT];

   always_comb begin
      next_cfg      = cfg;
      next_ctl2     = ctl2;
      next_chen     = chen;
      next_irq_en   = irq_en;
      next_state    = state;
      next_hw_run   = hw_run;
      next_cur_ch   = cur_ch;
      next_tick_cnt = tick_cnt;
      next_result   = result;
      irq_set       = '0;
      irq_clr       = '0;
      pick          = 3'b000;
      next_pre_cnt  = (!powered || tick) ? 4'h0 : pre_cnt + 4'h1;
      if (cfg_wr) begin
         next_cfg = (w_byte & CFG_WMASK & ~(8'h01 << CFG_START_BIT)) | (cfg & (8'h01 << CFG_START_BIT));
         // A start is kept only when the new setting leaves the converter on and no hardware run owns it.
         if (soft_wr && w_byte[CFG_POWER_BIT] && !hw_run) begin
            next_cfg[CFG_START_BIT] = 1'b1;
         end
      end
      if (soft_wr && hw_run) begin
         irq_set[IRQ_DROP] = 1'b1;
      end
      if (wr_lane0 && aw_addr == CTL2_ADDR) next_ctl2 = w_byte;
      if (wr_lane0 && aw_addr == CHEN_ADDR) next_chen = w_byte[3:0];
      if (wr_lane0 && aw_addr == IRQ_EN_ADDR) next_irq_en = w_byte[IRQ_W-1:0];
      if (wr_lane0 && aw_addr == IRQ_CLR_ADDR) irq_clr = w_byte[IRQ_W-1:0];
      case (state)
         ST_IDLE: begin
            if (powered && cfg[CFG_START_BIT]) begin
               next_state = ST_HOLD;
            end else if (powered && hw_trigger) begin
               next_state  = ST_HOLD;
               next_hw_run = 1'b1;
            end
         end
         ST_HOLD: begin
            if (tick) begin
               pick          = next_chan(chen, 2'b00, 1'b1);
               next_cur_ch   = pick[1:0];
               next_tick_cnt = 6'd0;
               next_state    = pick[2] ? ST_CONV : ST_DONE;
            end
         end
         ST_CONV: begin
            if (tick) begin
               next_tick_cnt = tick_cnt + 6'd1;
               if (tick_cnt == CONV_LAST) begin
                  next_result[cur_ch] = core_result;
                  pick          = next_chan(chen, cur_ch, 1'b0);
                  next_cur_ch   = pick[2] ? pick[1:0] : cur_ch;
                  next_tick_cnt = 6'd0;
                  next_state    = pick[2] ? ST_CONV : ST_DONE;
               end
            end
         end
         ST_DONE: begin
            irq_set[IRQ_DONE]       = 1'b1;
            next_cfg[CFG_START_BIT] = 1'b0;
            next_hw_run             = 1'b0;
            next_state              = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
      // Dropping power abandons any sequence, so neither a start nor a completion can survive it.
      if (!next_cfg[CFG_POWER_BIT]) begin
         next_cfg[CFG_START_BIT] = 1'b0;
         next_state              = ST_IDLE;
         next_hw_run             = 1'b0;
         irq_set[IRQ_DONE]       = 1'b0;
      end
      next_irq_st = (irq_st & ~irq_clr) | irq_set;
      next_core.powered_down  = !next_cfg[CFG_POWER_BIT];
      next_core.hold          = (next_state == ST_HOLD || next_state == ST_CONV) ? th_en : 2'b00;
      next_core.convert_start = next_state == ST_CONV && next_tick_cnt == 6'd0 && (state != ST_CONV || tick);
      next_core.channel       = next_cur_ch;
      next_core.conv_clk_tick = tick;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg      <= CFG_RESET;
         ctl2     <= CTL2_RESET;
         chen     <= CHEN_RESET;
         irq_st   <= '0;
         irq_en   <= '0;
         state    <= ST_IDLE;
         hw_run   <= 1'b0;
         pre_cnt  <= 4'h0;
         tick_cnt <= 6'd0;
         cur_ch   <= 2'b00;
         result   <= '{default: '0};
         core     <= '{powered_down: 1'b1, default: '0};
      end else if (ce) begin
         cfg      <= next_cfg;
         ctl2     <= next_ctl2;
         chen     <= next_chen;
         irq_st   <= next_irq_st;
         irq_en   <= next_irq_en;
         state    <= next_state;
         hw_run   <= next_hw_run;
         pre_cnt  <= next_pre_cnt;
         tick_cnt <= next_tick_cnt;
         cur_ch   <= next_cur_ch;
         result   <= next_result;
         core     <= next_core;
      end
   end

   // The done bit reaches the pin only through done_irq_enable as well as its own mask bit.
   assign irq = |(irq_st & irq_en & {1'b1, cfg[CFG_IRQE_BIT]});

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence seq_launch;
      ce && state == ST_IDLE ##1 state == ST_HOLD;
   endsequence

   sequence seq_capture;
      ce && state == ST_CONV && tick && tick_cnt == CONV_LAST;
   endsequence

   a_power_abort: assert property ((ce && !cfg[CFG_POWER_BIT]) |=> state == ST_IDLE && !irq_st[IRQ_DONE] || $past(irq_st[IRQ_DONE]))
      else $error("sequence kept running while powered down");
   a_irq_gate: assert property (irq |-> (irq_st[IRQ_DONE] && irq_en[IRQ_DONE] && cfg[CFG_IRQE_BIT])
                                       || (irq_st[IRQ_DROP] && irq_en[IRQ_DROP]))
      else $error("interrupt raised without an enabled cause");
   a_start_selfclear: assert property ((ce && state == ST_DONE) |=> !cfg[CFG_START_BIT] && state == ST_IDLE)
      else $error("start bit not cleared at end of sequence");
   a_hw_ignore: assert property (hw_run |-> !cfg[CFG_START_BIT])
      else $error("software start accepted during hardware run");
   a_conv_len: assert property (seq_capture |-> $past(tick_cnt, 1) == CONV_LAST || !$past(ce))
      else $error("conversion ended off the 32nd converter clock");
   a_div_wrap: assert property ((ce && tick) |=> pre_cnt == 4'h0)
      else $error("prescaler did not wrap at its terminal count");
   a_hold_first: assert property (seq_launch |=> core.hold == $past(th_en) || !$past(ce))
      else $error("track/hold not placed in hold at trigger");
   a_done_event: assert property ((ce && state == ST_DONE) |=> irq_st[IRQ_DONE])
      else $error("completion event missing after sequence");

endmodule

/* pkg/sadc_pkg.sv */
package sadc_pkg;

   // Register map: the two printed offsets are indices, byte address is four times the index.
   localparam logic [11:0] CFG_INDEX      = 12'h0A9;
   localparam logic [11:0] CTL2_INDEX     = 12'h0CE;
   localparam logic [11:0] CFG_ADDR       = {CFG_INDEX[9:0], 2'b00};
   localparam logic [11:0] CTL2_ADDR      = {CTL2_INDEX[9:0], 2'b00};
   localparam logic [11:0] CHEN_ADDR      = 12'h000;
   localparam logic [11:0] STATE_ADDR     = 12'h004;
   localparam logic [11:0] IRQ_STAT_ADDR  = 12'h008;
   localparam logic [11:0] IRQ_CLR_ADDR   = 12'h00C;
   localparam logic [11:0] IRQ_EN_ADDR    = 12'h010;
   localparam logic [11:0] RESULT_BASE    = 12'h020;

   // Fields of converter_config.
   localparam int unsigned CFG_POWER_BIT  = 7;
   localparam int unsigned CFG_IRQE_BIT   = 5;
   localparam int unsigned CFG_START_BIT  = 4;
   localparam int unsigned CFG_JUST_BIT   = 3;
   localparam int unsigned CFG_DIV_HI_BIT = 1;
   localparam int unsigned CFG_DIV_LO_BIT = 0;
   localparam logic [7:0]  CFG_WMASK      = 8'hBB;
   localparam logic [7:0]  CFG_RESET      = 8'h00;

   // Fields of converter_control_two; bits 5 and 4 enable the two track/hold stages.
   localparam int unsigned CTL2_TH_LO_BIT = 4;
   localparam logic [7:0]  CTL2_RESET     = 8'h00;

   localparam int unsigned NUM_CH         = 4;
   localparam int unsigned RES_W          = 12;
   localparam logic [5:0]  CONV_CYCLES    = 6'd32;
   localparam logic [5:0]  CONV_LAST      = CONV_CYCLES - 6'd1;
   localparam logic [3:0]  CHEN_RESET     = 4'h0;

   localparam int unsigned IRQ_DONE       = 0;
   localparam int unsigned IRQ_DROP       = 1;
   localparam int unsigned IRQ_W          = 2;

   localparam logic [1:0]  RESP_OKAY      = 2'b00;
   localparam logic [1:0]  RESP_SLVERR    = 2'b10;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_HOLD = 4'b0010,
      ST_CONV = 4'b0100,
      ST_DONE = 4'b1000
   } sadc_state_e;

   typedef struct packed {
      logic       powered_down;
      logic [1:0] hold;
      logic       convert_start;
      logic [1:0] channel;
      logic       conv_clk_tick;
   } sadc_core_s;

endpackage

/* sim/sadc_core_model.sv */
`timescale 1ns/1ps
module sadc_core_model
   import sadc_pkg::*;
(
   input  wire logic        aclk,
   input  wire sadc_core_s  core,
   input  wire logic [47:0] level,
   output      logic [11:0] core_result
);
   logic [11:0] held = 12'h000;

   // An unpowered core gives nothing usable, so the line toggles every cycle rather than keep a stale value.
   always @(posedge aclk) begin
      if (core.powered_down) begin
         held <= ~held;
      end else if (core.convert_start) begin
         held <= level[core.channel*12 +: 12];
      end
   end
   assign core_result = held;
endmodule

/* sim/tb_top.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top;
   import sadc_pkg::*;
   typedef struct packed {logic [1:0] resp; logic [31:0] mask; logic [31:0] val;} sadc_note_s;
   logic        aclk = 0, aresetn = 0, ce = 1, hw_trigger = 0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rd_data;
   logic [3:0]  wstrb = 0;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0]  bresp, rresp, exp_hold = 0, cur_div = 0;
   logic [11:0] core_result;
   logic [47:0] level = 0;
   sadc_core_s  core;
   int          n_mismatch = 0, n_checks = 0, ticks = 0, gap = 0;
   integer      seed = 32'hE1FE;
   logic        first = 1;
   sadc_note_s  rq[$];
   logic [1:0]  wq[$], chq[$];

   always #25 aclk = ~aclk;

   sadc_sequencer_control i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .hw_trigger(hw_trigger), .core_result(core_result),
      .core(core), .irq(irq));
   sadc_core_model i_core (.aclk(aclk), .core(core), .level(level), .core_result(core_result));

   ////////////////////////////////////////////////////////////////////////////////
   // Watcher: bus answers against the notes, converter timing against the settings.
   always @(posedge aclk) begin
      sadc_note_s n;
      if (rvalid && rready) begin
         n = (rq.size() > 0) ? rq.pop_front() : '1;
         `CHK("rdata", n.val, rdata & n.mask)
         `CHK("rresp", n.resp, rresp)
      end
      if (bvalid && bready) begin
         `CHK("bresp", (wq.size() > 0) ? wq.pop_front() : 2'b11, bresp)
      end
      if (core.conv_clk_tick) begin
         if (!first) `CHK("tick gap", 2 << cur_div, gap)
         gap = 1;
         ticks++;
      end else begin
         gap++;
      end
      if (core.convert_start) begin
         if (!first) `CHK("ticks per channel", 32, ticks)
         `CHK("channel", (chq.size() > 0) ? chq.pop_front() : 2'bxx, core.channel)
         `CHK("hold", exp_hold, core.hold)
         `CHK("power", 1'b0, core.powered_down)
         ticks = 0;
         first = 0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
      logic aw_ok, w_ok;
      @(posedge aclk);
      wq.push_back(r);
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_ok = 0;
      w_ok = 0;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (awvalid && awready) begin
            awvalid <= 1'b0;
            aw_ok = 1;
         end
         if (wvalid && wready) begin
            wvalid <= 1'b0;
            w_ok = 1;
         end
      end
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF,
                     input logic [1:0] r = RESP_OKAY);
      @(posedge aclk);
      rq.push_back('{r, m, e});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!(arvalid && arready));
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rd_data = rdata;
      rready <= 1'b0;
   endtask

   // One sequence; with hw set the hardware trigger starts it and a software start lands mid-run.
   task automatic seq(input logic [3:0] chm, input logic [1:0] dv, input logic js, input logic hw);
      logic [11:0] r;
      logic [7:0]  base;
      int          i;
      level <= {16'($random(seed)), 32'($random(seed))};
      exp_hold = 2'($random(seed));
      base = 8'hA0 | {4'h0, js, 1'b0, dv};
      wr(CHEN_ADDR, {4'h0, chm});
      wr(CTL2_ADDR, {2'b00, exp_hold, 4'h0});
      cur_div = dv;
      first = 1;
      for (i = 0; i < 4; i++) if (chm[i]) chq.push_back(2'(i));
      if (hw) begin
         // The dropped-start flag would raise the pin mid-run, so only the done bit may end the wait.
         wr(IRQ_EN_ADDR, 8'h01);
         wr(CFG_ADDR, base);
         @(posedge aclk) hw_trigger <= 1'b1;
         @(posedge aclk) hw_trigger <= 1'b0;
      end
      wr(CFG_ADDR, base | 8'h10);
      i = 0;
      while (!irq && i < 5000) begin
         @(posedge aclk);
         i++;
      end
      `CHK("irq raised", 1'b1, irq)
      rd(CFG_ADDR, {24'h0, base}, hw ? 32'hEF : 32'hFF);
      rd(IRQ_STAT_ADDR, {31'h0, 1'b1} | {30'h0, hw, 1'b0});
      for (i = 0; i < 4; i++) begin
         r = level[i*12 +: 12];
         if (chm[i]) begin
            rd(RESULT_BASE + 12'(8*i), js ? {24'h0, r[11:4]} : {28'h0, r[11:8]});
            rd(RESULT_BASE + 12'(8*i+4), js ? {24'h0, r[3:0], 4'h0} : {24'h0, r[7:0]});
         end
      end
      wr(IRQ_CLR_ADDR, 8'h03);
      @(posedge aclk);
      `CHK("irq cleared", 1'b0, irq)
      if (hw) wr(IRQ_EN_ADDR, 8'h03);
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [3:0] m;
      int         k;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(CFG_ADDR, {24'h0, CFG_RESET});
      rd(CTL2_ADDR, {24'h0, CTL2_RESET});
      rd(CHEN_ADDR, {28'h0, CHEN_RESET});
      `CHK("powered down", 1'b1, core.powered_down)
      rd(12'h100, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
      wr(12'h104, 8'h55, RESP_SLVERR);
      wr(IRQ_EN_ADDR, 8'h03);
      wr(CFG_ADDR, 8'h80);
      repeat (400) @(posedge aclk);
      // Divide code 00 would run the converter clock at 10 MHz, so it stays unused.
      for (k = 1; k < 4; k++) begin
         m = 4'($random(seed));
         seq((m == 4'h0) ? 4'h5 : m, 2'(k), k[0], 1'b0);
      end
      seq(4'hF, 2'd1, 1'b0, 1'b1);
      for (k = 0; k < 4; k++) chq.push_back(2'(k));
      first = 1;
      wr(CFG_ADDR, 8'h91);
      k = 0;
      do begin
         rd(STATE_ADDR, 32'h0, 32'h0);
         k++;
      end while (rd_data[3:0] !== 4'h1 && k < 200);
      `CHK("irq masked", 1'b0, irq)
      rd(IRQ_STAT_ADDR, 32'h1);
      wr(IRQ_CLR_ADDR, 8'h01);
      wr(CFG_ADDR, 8'h30);
      @(posedge aclk) hw_trigger <= 1'b1;
      @(posedge aclk) hw_trigger <= 1'b0;
      repeat (200) @(posedge aclk);
      `CHK("off powered down", 1'b1, core.powered_down)
      rd(STATE_ADDR, 32'h1, 32'h0F);
      rd(IRQ_STAT_ADDR, 32'h0);
      `CHK("irq off", 1'b0, irq)
      give_verdict();
   end

   initial begin
      repeat (40000) @(posedge aclk);
      n_mismatch++;
      $display("[FAIL] watchdog expected finish seen hang");
      give_verdict();
   end
endmodule
